// file: bench/sensor_out_timing_bench.sv
// self-checking bench for the sensor output timing block
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module sensor_out_timing_bench
   import sensor_out_pkg::*;
;
   localparam int         COLS = 8;
   localparam int         ROWS = 3;
   localparam int         HB   = 2;
   localparam logic [6:0] ADDR = 7'h48;
   logic       clk_sys = 1'b0;
   logic       resetn = 1'b0;
   logic [9:0] pix_data_in = 10'h2a5;
   logic       standby_req = 1'b0;
   logic [7:0] rd_data = 8'h3c;
   logic [9:0] pixel_data_out;
   logic       row_active_flag, image_active_flag, sample_clock_out, low_power;
   logic       serial_data_line_out, serial_data_line_oe, wr_strobe, rd_take;
   logic [7:0] wr_data, last_wr;
   wire logic  scl, sda_low;
   wire logic  sda_wire = !(serial_data_line_oe || sda_low);
   logic       row_q = 1'b0, img_q = 1'b0, sc_q = 1'b0;
   int         n_fail = 0, num_checks = 0, cyc = 0, n_wr = 0, n_rd = 0;

   // the master clock never stops, so a pending standby can finish its frame
   always #5 clk_sys = ~clk_sys;

   sensor_out_timing #(.PIX_W(10), .COLS(COLS), .ROWS(ROWS), .H_BLANK(HB), .V_BLANK(2),
      .DEV_ADDR(ADDR)) dut (
      .clk_sys(clk_sys), .resetn(resetn), .pix_data_in(pix_data_in),
      .standby_req(standby_req), .pixel_data_out(pixel_data_out),
      .row_active_flag(row_active_flag), .image_active_flag(image_active_flag),
      .sample_clock_out(sample_clock_out), .low_power(low_power), .scl_in(scl),
      .serial_data_line_in(sda_wire), .serial_data_line_out(serial_data_line_out),
      .serial_data_line_oe(serial_data_line_oe), .wr_data(wr_data), .wr_strobe(wr_strobe),
      .rd_data(rd_data), .rd_take(rd_take));

   two_wire_master_model mdl (.clk_sys(clk_sys), .sda(sda_wire), .scl(scl), .sda_low(sda_low));

   always @(negedge clk_sys) begin
      if (resetn) begin
         if (row_active_flag !== row_q || image_active_flag !== img_q)
            `CHK({sc_q, sample_clock_out}, 2'b10)
         `CHK(pixel_data_out, row_active_flag ? pix_data_in : 10'h000)
         if (serial_data_line_oe) `CHK(serial_data_line_out, 1'b0)
         if (low_power) `CHK({row_active_flag, image_active_flag, sample_clock_out}, 3'b000)
      end
      row_q <= row_active_flag;
      img_q <= image_active_flag;
      sc_q  <= sample_clock_out;
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (wr_strobe === 1'b1) begin
         n_wr++;
         last_wr = wr_data;
      end
      if (rd_take === 1'b1) begin
         n_rd++;
         #1 rd_data = ~rd_data;
      end
      if (cyc == 40000) begin
         n_fail++;
         results();
      end
   end

   // sel picks row flag, image flag or low_power
   task automatic cnt_until(input int sel, input logic lv, input int lim, output int n);
      logic [2:0] s;
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
         s = {low_power, image_active_flag, row_active_flag};
      end while (s[sel] !== lv && n < lim);
   endtask

   task automatic t_reset();
      repeat (5) @(posedge clk_sys);
      #1;
      `CHK({pixel_data_out, row_active_flag, image_active_flag, sample_clock_out, low_power,
         serial_data_line_oe, wr_strobe, rd_take}, 17'h00000)
      repeat (RESET_HOLD_CYC) @(posedge clk_sys);
      #1 resetn = 1'b1;
   endtask

   task automatic t_frame();
      int n;
      cnt_until(1, 1'b1, 2000, n);
      cnt_until(0, 1'b1, 2000, n);
      `CHK(n, FRONT_SYS)
      for (int r = 0; r < ROWS; r++) begin
         cnt_until(0, 1'b0, 2000, n);
         `CHK(n, 2 * COLS)
         if (r < ROWS - 1) begin
            cnt_until(0, 1'b1, 2000, n);
            `CHK(n, 2 * HB)
         end
      end
      cnt_until(1, 1'b0, 2000, n);
      `CHK(n, BACK_SYS)
   endtask

   task automatic t_write();
      logic a;
      int   w0;
      repeat (BUS_WAIT_EDGES + 2) @(posedge clk_sys);
      // keep every serial line change off the master clock edges
      #1;
      w0 = n_wr;
      mdl.start();
      mdl.byte_wr({ADDR, 1'b0}, a);
      `CHK(a, 1'b0)
      `CHK(mdl.ack_dly >= SDA_HOLD_CYC && mdl.ack_dly <= SDA_HOLD_CYC + 6, 1'b1)
      mdl.byte_wr(8'ha5, a);
      `CHK(a, 1'b0)
      mdl.stop();
      `CHK(n_wr - w0, 1)
      `CHK(last_wr, 8'ha5)
   endtask

   // read two bytes, then restart straight after the no-acknowledge to a foreign address
   task automatic t_read();
      logic       a;
      logic [7:0] d;
      int         r0;
      r0 = n_rd;
      mdl.start();
      mdl.byte_wr({ADDR, 1'b1}, a);
      `CHK(a, 1'b0)
      mdl.byte_rd(1'b0, d);
      `CHK(d, 8'h3c)
      mdl.byte_rd(1'b1, d);
      `CHK(d, 8'hc3)
      `CHK(n_rd - r0, 2)
      mdl.start();
      mdl.byte_wr({ADDR ^ 7'h01, 1'b0}, a);
      `CHK(a, 1'b1)
      mdl.stop();
   endtask

   task automatic t_standby();
      logic a;
      int   n, w0;
      cnt_until(0, 1'b1, 2000, n);
      standby_req = 1'b1;
      repeat (10) @(posedge clk_sys);
      #1;
      `CHK(low_power, 1'b0)
      cnt_until(1, 1'b0, 2000, n);
      cnt_until(2, 1'b1, 8, n);
      `CHK(low_power, 1'b1)
      cnt_until(1, 1'b1, 1000, n);
      `CHK(n, 1000)
      w0 = n_wr;
      mdl.start();
      mdl.byte_wr({ADDR, 1'b0}, a);
      `CHK(a, 1'b1)
      mdl.stop();
      `CHK(n_wr - w0, 0)
      standby_req = 1'b0;
      cnt_until(2, 1'b0, 8, n);
      `CHK(low_power, 1'b0)
   endtask

   task automatic results();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      t_reset();
      t_frame();
      t_write();
      t_read();
      t_standby();
      results();
   end
endmodule

// file: bench/two_wire_master_model.sv
// two-wire bus master model with an open-drain pull on the data line
`timescale 1ns/1ps
module two_wire_master_model #(
   parameter int HALF_NS = 500
) (
   // master clock, used only to time the slave answers
   input  wire logic clk_sys,
   // serial lines
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   int  ack_dly;
   time t0;
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
      ack_dly = 0;
   end
   // data moves only a quarter of the way into the clock low phase
   task automatic put_bit(input logic b, output logic seen);
      #(HALF_NS / 4) sda_low = ~b;
      #(HALF_NS * 3 / 4) scl = 1'b1;
      seen = sda;
      #(HALF_NS) scl = 1'b0;
   endtask
   // also serves as repeated start after a no-acknowledge
   task automatic start();
      #(HALF_NS / 4) sda_low = 1'b0;
      #(HALF_NS / 4) scl = 1'b1;
      #(HALF_NS) sda_low = 1'b1;
      #(HALF_NS) scl = 1'b0;
   endtask
   task automatic stop();
      #(HALF_NS / 4) sda_low = 1'b1;
      #(HALF_NS * 3 / 4) scl = 1'b1;
      #(HALF_NS) sda_low = 1'b0;
      #(HALF_NS);
   endtask
   task automatic byte_wr(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(d[i], s);
      t0 = $time;
      fork
         put_bit(1'b1, ack);
         begin
            #(HALF_NS / 4 + 1);
            while (sda !== 1'b0 && $time < t0 + HALF_NS) @(posedge clk_sys);
            ack_dly = int'(($time - t0) / 10);
         end
      join
   endtask
   // ack_bit low acknowledges, high ends the read
   task automatic byte_rd(input logic ack_bit, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
      put_bit(ack_bit, s);
   endtask
endmodule

// file: core/sensor_out_timing.sv
// pixel output timing, standby sequencing and serial bus gating of the sensor
`timescale 1ns/1ps
// Notes on behaviour
// - qualifiers change on the same master clock edge as pixel data.
// - row flag rises with the first pixel, falls as the last ends.
// - image flag rises 143 sample clocks before the first row flag rise.
// - image flag falls 23 sample clocks after the last row flag fall.
// - serial line changes keep a least count of master clocks between them.
// - read data is only pulled low; the pull-up makes a high.
// - reset is needed at power-up; supplies may come in any order.
// - outputs hold defined levels while reset is held low; the synchronous reset sets them only from the first master clock edge.
// - reset alone does not enter the low-power state.
// - a standby request takes effect only after the frame in progress.
// - in standby pixel data and both qualifiers are driven low.
// - in standby the serial bus is ignored.
// - sample clock is an inverted master-derived clock falling with data.
module sensor_out_timing
   import sensor_out_pkg::*;
#(
   parameter int         PIX_W    = 10,
   parameter int         COLS     = 752,
   parameter int         ROWS     = 480,
   parameter int         H_BLANK  = 61,
   parameter int         V_BLANK  = 45,
   parameter logic [6:0] DEV_ADDR = 7'h48
) (
   // master clock and reset
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   // sensor core pixel stream and standby pin
   input  wire logic [PIX_W-1:0] pix_data_in,
   input  wire logic             standby_req,
   // pixel output port
   output logic [PIX_W-1:0]      pixel_data_out,
   output logic                  row_active_flag,
   output logic                  image_active_flag,
   output logic                  sample_clock_out,
   output logic                  low_power,
   // two-wire serial bus
   input  wire logic             scl_in,
   input  wire logic             serial_data_line_in,
   output logic                  serial_data_line_out,
   output logic                  serial_data_line_oe,
   // register side of the serial bus
   output logic [7:0]            wr_data,
   output logic                  wr_strobe,
   input  wire logic [7:0]       rd_data,
   output logic                  rd_take
);
   initial begin
      if (COLS < 1 || ROWS < 1 || H_BLANK < 1 || V_BLANK < 1) $error("bad frame geometry");
      if (COLS >= (1 << CNT_W) || ROWS >= (1 << CNT_W)) $error("frame too large");
      if (H_BLANK >= (1 << CNT_W) || V_BLANK >= (1 << CNT_W)) $error("blanking too long");
   end

   function automatic logic at_end(input logic [CNT_W-1:0] c, input int n);
      return c == CNT_W'(n - 1);
   endfunction

   logic [1:0]         stby_q;
   logic               stby_pend_reg, stby_pend_next;
   logic               phase_reg;
   logic [CNT_W-1:0]   cnt_reg, cnt_next;
   logic [CNT_W-1:0]   row_reg, row_next;
   logic [GUARD_W-1:0] guard_reg;
   video_state_t       state_reg, state_next;

   wire stby_req  = stby_q[1];
   // one sample clock period is two master clocks; data moves on the odd one
   wire tick      = phase_reg;
   wire in_stby   = state_next == S_STANDBY;
   wire row_on    = state_next == S_ROW;
   wire image_on  = state_next == S_FRONT || state_next == S_ROW
                    || state_next == S_HBLANK || state_next == S_BACK;
   wire guard_ok  = guard_reg == GUARD_W'(BUS_WAIT_EDGES);
   wire bus_en    = guard_ok && state_reg != S_STANDBY;

   // a request seen mid-frame is held until the frame has finished
   assign stby_pend_next = stby_req | (stby_pend_reg & (state_reg != S_STANDBY));

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      row_next   = row_reg;
      if (tick) begin
         unique case (state_reg)
            S_VBLANK: begin
               if (stby_pend_reg) begin
                  state_next = S_STANDBY;
               end else if (at_end(cnt_reg, V_BLANK)) begin
                  state_next = S_FRONT;
                  cnt_next   = '0;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
            S_FRONT: begin
               if (at_end(cnt_reg, FRONT_PCLK)) begin
                  state_next = S_ROW;
                  cnt_next   = '0;
                  row_next   = '0;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
            S_ROW: begin
               if (at_end(cnt_reg, COLS)) begin
                  state_next = at_end(row_reg, ROWS) ? S_BACK : S_HBLANK;
                  cnt_next   = '0;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
            S_HBLANK: begin
               if (at_end(cnt_reg, H_BLANK)) begin
                  state_next = S_ROW;
                  cnt_next   = '0;
                  row_next   = row_reg + 1'b1;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
            S_BACK: begin
               if (at_end(cnt_reg, BACK_PCLK)) begin
                  state_next = S_VBLANK;
                  cnt_next   = '0;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
            S_STANDBY: begin
               if (!stby_pend_reg) begin
                  state_next = S_VBLANK;
                  cnt_next   = '0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         stby_q        <= 2'b00;
         stby_pend_reg <= 1'b0;
         phase_reg     <= 1'b0;
         state_reg     <= S_VBLANK;
         cnt_reg       <= '0;
         row_reg       <= '0;
      end else begin
         stby_q        <= {stby_q[0], standby_req};
         stby_pend_reg <= stby_pend_next;
         phase_reg     <= ~phase_reg;
         state_reg     <= state_next;
         cnt_reg       <= cnt_next;
         row_reg       <= row_next;
      end
   end

   // the bus stays deaf until enough master clocks follow the reset release
   always_ff @(posedge clk_sys) begin
      if (!resetn) guard_reg <= '0;
      else if (!guard_ok) guard_reg <= guard_reg + 1'b1;
   end

   // reset gives every output a fixed low level; the synchronous reset needs a
   // running master clock, so levels before its first edge rely on pad defaults
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pixel_data_out    <= '0;
         row_active_flag   <= RST_LEVEL;
         image_active_flag <= RST_LEVEL;
         sample_clock_out  <= RST_LEVEL;
         low_power         <= 1'b0;
      end else begin
         // falls on the data edge so the receiver can sample on the rise
         sample_clock_out <= in_stby ? 1'b0 : ~phase_reg;
         low_power        <= in_stby;
         if (tick) begin
            pixel_data_out    <= row_on ? pix_data_in : '0;
            row_active_flag   <= row_on;
            image_active_flag <= image_on;
         end
      end
   end

   two_wire_slave #(
      .DEV_ADDR (DEV_ADDR),
      .HOLD_CYC (SDA_HOLD_CYC)
   ) u_bus (
      .clk_sys              (clk_sys),
      .resetn               (resetn),
      .enable               (bus_en),
      .scl_in               (scl_in),
      .serial_data_line_in  (serial_data_line_in),
      .serial_data_line_out (serial_data_line_out),
      .serial_data_line_oe  (serial_data_line_oe),
      .wr_data              (wr_data),
      .wr_strobe            (wr_strobe),
      .rd_data              (rd_data),
      .rd_take              (rd_take)
   );

   // helper counters for the placement checks
   logic [CNT_W-1:0] img_age_reg, low_age_reg, row_len_reg;
   logic             row_seen_reg;
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         img_age_reg  <= '0;
         low_age_reg  <= '0;
         row_len_reg  <= '0;
         row_seen_reg <= 1'b0;
      end else begin
         img_age_reg  <= image_active_flag ? img_age_reg + 1'b1 : '0;
         low_age_reg  <= row_active_flag ? '0 : low_age_reg + 1'b1;
         row_len_reg  <= row_active_flag ? row_len_reg + 1'b1 : '0;
         row_seen_reg <= image_active_flag & (row_seen_reg | row_active_flag);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_req_in_frame;
      image_active_flag && stby_req;
   endsequence

   a_front_gap: assert property (
      ($rose(row_active_flag) && !row_seen_reg) |-> img_age_reg == CNT_W'(FRONT_SYS))
      else $error("image flag lead before first row is wrong");
   a_back_gap: assert property (
      $fell(image_active_flag) |-> low_age_reg == CNT_W'(BACK_SYS))
      else $error("image flag trail after last row is wrong");
   a_row_length: assert property (
      $fell(row_active_flag) |-> row_len_reg == CNT_W'(COLS * PCLK_DIV))
      else $error("row flag width differs from the row length");
   a_qual_with_data: assert property (
      ($changed(row_active_flag) || $changed(image_active_flag)) |-> !sample_clock_out)
      else $error("qualifier moved off the data edge");
   a_standby_blank: assert property (
      low_power |-> pixel_data_out == '0 && !row_active_flag && !image_active_flag)
      else $error("outputs not low in standby");
   a_frame_finish: assert property (
      s_req_in_frame |-> !low_power ##1 !low_power)
      else $error("standby entered inside a frame");
   a_reset_awake: assert property (
      disable iff (1'b0) !resetn |=> !low_power)
      else $error("reset entered the low-power state");
   a_bus_quiet: assert property (
      ($past(low_power) && low_power) |-> !serial_data_line_oe && !wr_strobe)
      else $error("serial bus active in standby");
endmodule

// file: core/two_wire_slave.sv
// two-wire serial slave: byte transfer with acknowledge handling
`timescale 1ns/1ps
module two_wire_slave
   import sensor_out_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h48,
   parameter int         HOLD_CYC = SDA_HOLD_CYC
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       enable,
   // serial lines
   input  wire logic       scl_in,
   input  wire logic       serial_data_line_in,
   output logic            serial_data_line_out,
   output logic            serial_data_line_oe,
   // register side
   output logic [7:0]      wr_data,
   output logic            wr_strobe,
   input  wire logic [7:0] rd_data,
   output logic            rd_take
);
   initial begin
      if (HOLD_CYC < 1 || HOLD_CYC >= (1 << WAIT_W)) $error("hold count out of range");
   end

   logic [1:0]        scl_q, sda_q;
   logic              scl_p, sda_p;
   logic [WAIT_W-1:0] wait_reg;
   logic [BIT_W-1:0]  bit_reg;
   logic [7:0]        shift_reg;
   logic              mack_reg;
   bus_state_t        state_reg;

   wire scl_s  = scl_q[1];
   wire sda_s  = sda_q[1];
   wire rise   = scl_s & ~scl_p;
   wire fall   = ~scl_s & scl_p;
   wire start  = scl_s & scl_p & sda_p & ~sda_s;
   wire stop   = scl_s & scl_p & ~sda_p & sda_s;
   wire at_ack = bit_reg == BIT_W'(ACK_SLOT);
   wire at_lst = bit_reg == BIT_W'(BYTE_LAST);
   wire held   = ~scl_s && wait_reg == WAIT_W'(HOLD_CYC);
   wire match  = shift_reg[7:1] == DEV_ADDR;
   // only a low level is ever driven; a high comes from the pull-up
   wire want_low = enable && (((state_reg == B_ADDR || state_reg == B_WDATA) && at_ack)
                   || (state_reg == B_RDATA && !at_ack && !shift_reg[7]));

   assign serial_data_line_out = 1'b0;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         scl_q <= 2'b11;
         sda_q <= 2'b11;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_q <= {scl_q[0], scl_in};
         sda_q <= {sda_q[0], serial_data_line_in};
         scl_p <= scl_s;
         sda_p <= sda_s;
      end
   end

   // the slave lets a fixed number of master clocks pass after each clock fall
   always_ff @(posedge clk_sys) begin
      if (!resetn) wait_reg <= '0;
      else if (fall) wait_reg <= '0;
      else if (!held && !scl_s) wait_reg <= wait_reg + 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) serial_data_line_oe <= 1'b0;
      else if (!enable) serial_data_line_oe <= 1'b0;
      else if (held) serial_data_line_oe <= want_low;
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_reg <= B_IDLE;
         bit_reg   <= '0;
         shift_reg <= '0;
         mack_reg  <= 1'b0;
         wr_data   <= '0;
         wr_strobe <= 1'b0;
         rd_take   <= 1'b0;
      end else begin
         wr_strobe <= 1'b0;
         rd_take   <= 1'b0;
         if (!enable || stop) begin
            state_reg <= B_IDLE;
         end else if (start) begin
            state_reg <= B_ADDR;
            // the clock fall that closes the start condition wraps this to zero
            bit_reg   <= '1;
         end else if (rise && state_reg != B_IDLE) begin
            if (at_ack) mack_reg <= ~sda_s;
            else if (state_reg != B_RDATA) shift_reg <= {shift_reg[6:0], sda_s};
         end else if (fall && state_reg != B_IDLE) begin
            if (at_lst) begin
               bit_reg <= BIT_W'(ACK_SLOT);
               if (state_reg == B_ADDR && !match) state_reg <= B_IDLE;
               if (state_reg == B_WDATA) begin
                  wr_data   <= shift_reg;
                  wr_strobe <= 1'b1;
               end
            end else if (at_ack) begin
               bit_reg <= '0;
               if ((state_reg == B_ADDR && shift_reg[0]) || state_reg == B_RDATA) begin
                  // a released acknowledge after a read byte ends the read
                  state_reg <= (state_reg == B_RDATA && !mack_reg) ? B_IDLE : B_RDATA;
                  shift_reg <= rd_data;
                  rd_take   <= state_reg == B_ADDR || mack_reg;
               end else begin
                  state_reg <= B_WDATA;
               end
            end else begin
               bit_reg <= bit_reg + 1'b1;
               if (state_reg == B_RDATA) shift_reg <= {shift_reg[6:0], 1'b0};
            end
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_sda_after_hold: assert property (
      ($changed(serial_data_line_oe) && $past(enable) && enable)
      |-> $past(!scl_s && wait_reg == WAIT_W'(HOLD_CYC)))
      else $error("data line moved before the hold time");
   a_start_to_addr: assert property (
      (enable && start && !stop) |=> state_reg == B_ADDR && bit_reg == '1)
      else $error("start condition not taken");
endmodule

// file: include/sensor_out_pkg.sv
// constants and types shared by the sensor output timing block
package sensor_out_pkg;
   // qualifier placement, counted in sample clock periods
   localparam int FRONT_PCLK = 143;
   localparam int BACK_PCLK  = 23;
   // master clock cycles per sample clock period
   localparam int PCLK_DIV   = 2;
   localparam int FRONT_SYS  = FRONT_PCLK * PCLK_DIV;
   localparam int BACK_SYS   = BACK_PCLK * PCLK_DIV;
   // master clock period and reset figures
   localparam int CLK_NS         = 10;
   localparam int RESET_HOLD_NS  = 750;
   localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int BUS_WAIT_EDGES = 10;
   // data hold after a serial clock fall, least time
   localparam int SDA_HOLD_NS  = 300;
   localparam int SDA_HOLD_CYC = (SDA_HOLD_NS + CLK_NS - 1) / CLK_NS;
   // counter widths and reset values
   localparam int CNT_W       = 16;
   localparam int GUARD_W     = 4;
   localparam int WAIT_W      = 6;
   localparam int BIT_W       = 4;
   localparam int BYTE_LAST   = 7;
   localparam int ACK_SLOT    = 8;
   localparam logic RST_LEVEL = 1'b0;

   typedef enum logic [2:0] {
      S_VBLANK, S_FRONT, S_ROW, S_HBLANK, S_BACK, S_STANDBY
   } video_state_t;

   typedef enum logic [1:0] {
      B_IDLE, B_ADDR, B_WDATA, B_RDATA
   } bus_state_t;
endpackage
